// >>> hw/fcc_top.sv
`timescale 1ns/1ps
module fcc_top (
	// Clock and reset
	input logic i_core_clk,
	input logic i_rst,
	// Host register channel
	input logic i_chan_wr,
	input logic i_chan_rd,
	input logic [3:0] i_chan_station,
	input logic [15:0] i_chan_wdata,
	input logic i_chan_protect,
	output logic [15:0] o_chan_rdata,
	// Memory access channel
	output logic o_mem_req,
	output logic o_mem_we,
	output logic [15:0] o_mem_addr,
	output logic [15:0] o_mem_wdata,
	input logic i_mem_ack,
	input logic [15:0] i_mem_rdata,
	// Status
	output logic o_active,
	output logic [15:0] o_status
);
	fcc_pkg::fcc_regs_t r;
	fcc_pkg::fcc_regs_t nx;

	// -------------------------------------------------------------
	// Arithmetic helpers
	// -------------------------------------------------------------
	function automatic logic [15:0] f_oc_add(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[15:0] + {15'h0, s[16]};
	endfunction

	function automatic logic f_is_float(input logic [3:0] c);
		return c inside {fcc_pkg::C_SUB, fcc_pkg::C_MUL, fcc_pkg::C_DIV, fcc_pkg::C_LOAD,
			fcc_pkg::C_STORE, fcc_pkg::C_ADD};
	endfunction

	function automatic logic [51:0] f_sat(input logic s);
		return s ? {1'b1, 47'h0, 4'hf} : {1'b0, 47'h7fff_ffff_ffff, 4'h0};
	endfunction

	// Normalizes, range-checks, rounds and complements a magnitude result.
	function automatic logic [51:0] f_finish(input logic s, input int e, input logic [43:0] m,
		input logic dp);
		logic [51:0] v;
		int ee;
		logic [43:0] mm;
		int lsb;
		ee = e;
		mm = m;
		if (mm[43])
		begin
			mm = mm >> 1;
			ee = ee + 1;
		end
		for (int i = 0; i < 43; i++)
			if (!mm[42] && mm != 44'h0)
			begin
				mm = mm << 1;
				ee = ee - 1;
			end
		lsb = dp ? fcc_pkg::LSB_DP : fcc_pkg::LSB_SP;
		if (mm == 44'h0)
			return 52'h0;
		if (ee > fcc_pkg::EXP_MAX)
			return f_sat(s);
		if (ee < fcc_pkg::EXP_MIN)
			return 52'h0;
		v = {1'b0, 8'(ee + fcc_pkg::EXP_BIAS), mm[42:0]};
		if (s)
			v = ~v;
		if (!s && v[lsb-1])
			v = v + (52'h1 << lsb);
		else if (s && !v[lsb-1])
			v = v - (52'h1 << lsb);
		for (int i = 0; i < fcc_pkg::LSB_SP; i++)
			if (i < lsb)
				v[i] = s;
		return v;
	endfunction

	function automatic void f_unpack(input logic [51:0] a, output logic s, output int e,
		output logic [43:0] m);
		logic [51:0] t;
		s = a[51];
		t = s ? ~a : a;
		e = int'(t[50:43]) - fcc_pkg::EXP_BIAS;
		m = {1'b0, t[42:0]};
	endfunction

	function automatic logic [51:0] f_arith(input logic [3:0] c, input logic [51:0] a,
		input logic [51:0] b, input logic dp);
		logic sa, sb, sr;
		int ea, eb, er;
		logic [43:0] ma, mb, mr;
		logic [87:0] p;
		logic [86:0] q;
		f_unpack(a, sa, ea, ma);
		f_unpack(b, sb, eb, mb);
		sr = sa ^ sb;
		er = ea + eb;
		mr = 44'h0;
		case (c)
			fcc_pkg::C_MUL:
			begin
				p = {44'h0, ma} * {44'h0, mb};
				mr = p[86:43];
			end
			fcc_pkg::C_DIV:
			begin
				if (!mb[42])
					return f_sat(sa);
				q = {ma, 43'h0} / {43'h0, mb};
				mr = q[43:0];
				er = ea - eb;
			end
			default:
			begin
				if (c == fcc_pkg::C_SUB)
					sb = ~sb;
				if (mb == 44'h0 || (ma != 44'h0 && ea >= eb))
				begin
					mb = (ea - eb > 43) ? 44'h0 : mb >> (ea - eb);
					er = ea;
				end
				else
				begin
					ma = (eb - ea > 43) ? 44'h0 : ma >> (eb - ea);
					er = eb;
				end
				sr = (sa == sb || ma >= mb) ? sa : sb;
				mr = (sa == sb) ? ma + mb : (ma >= mb ? ma - mb : mb - ma);
			end
		endcase
		return f_finish(sr, er, mr, dp);
	endfunction

	function automatic logic [51:0] f_words(input logic [2:0][15:0] w, input logic dp);
		return dp ? {w[0], w[1], w[2], {4{w[0][15]}}} : {w[0], w[1], {20{w[0][15]}}};
	endfunction

	function automatic logic [15:0] f_f2i(input logic [51:0] a);
		logic s;
		int e;
		logic [43:0] m;
		logic [14:0] mag;
		f_unpack(a, s, e, m);
		if (m == 44'h0 || e <= 0)
			mag = 15'h0;
		else if (e > fcc_pkg::INT_EXP)
			mag = 15'h7fff;
		else
			mag = 15'(m >> (43 - e));
		return (s && mag != 15'h0) ? {1'b1, ~mag} : {1'b0, mag};
	endfunction

	// Effective address; a prefixed chain passes C_SPECIAL_PREFIX_CMD so no index is added.
	function automatic logic [15:0] f_ea(input logic [15:0] ptr, input logic [15:0] seq,
		input logic [15:0] idx, input logic [15:0] st, input logic [3:0] c);
		logic [15:0] base, term;
		base = st[fcc_pkg::B_REL] ? f_oc_add(ptr, seq) : ptr;
		term = 16'h0;
		if (c == fcc_pkg::C_F2I || c == fcc_pkg::C_I2F)
			term = idx;
		else if (f_is_float(c))
			term = st[fcc_pkg::B_UNIT_IDX] ? idx : (st[fcc_pkg::B_DP] ?
				f_oc_add(f_oc_add(idx, idx), idx) : f_oc_add(idx, idx));
		return f_oc_add(base, term);
	endfunction

	// -------------------------------------------------------------
	// Sequencer and host channel
	// -------------------------------------------------------------
	always_comb
	begin
		logic [1:0] n;
		fcc_pkg::fcc_state_t after;
		logic dp;
		nx = r;
		dp = r.function_status_reg[fcc_pkg::B_DP];
		n = r.function_status_reg[13:12];
		after = (n == 2'h0) ? fcc_pkg::S_CMD : fcc_pkg::S_DEC;
		case (r.state)
			fcc_pkg::S_IDLE:
				if (r.stop_pend)
				begin
					nx.snap = r.function_status_reg;
					nx.function_status_reg[fcc_pkg::B_ACTIVE] = 1'b1;
					nx.cnt = 3'h0;
					nx.state = fcc_pkg::S_SAVE;
				end
			fcc_pkg::S_CMD, fcc_pkg::S_PTR:
				if (!r.req)
				begin
					nx.req = 1'b1;
					nx.we = 1'b0;
					nx.addr = r.sequence_pointer_reg;
				end
				else if (i_mem_ack)
				begin
					nx.req = 1'b0;
					nx.sequence_pointer_reg = f_oc_add(r.sequence_pointer_reg, 16'h1);
					nx.cnt = 3'h0;
					if (r.state == fcc_pkg::S_CMD)
					begin
						nx.command_word_reg = i_mem_rdata;
						nx.function_status_reg[13:12] = 2'h0;
						nx.state = fcc_pkg::S_DEC;
					end
					else
					begin
						nx.ea = f_ea(i_mem_rdata, r.sequence_pointer_reg, r.index_value_reg,
							r.function_status_reg, r.code);
						nx.total = (f_is_float(r.code) ? (dp ? 3'h3 : 3'h2) : 3'h1);
						nx.state = fcc_pkg::S_OPND;
						if (r.code == fcc_pkg::C_SPECIAL_PREFIX_CMD)
						begin
							nx.sequence_pointer_reg = nx.ea;
							nx.state = fcc_pkg::S_CMD;
						end
						else if (r.code == fcc_pkg::C_STX)
						begin
							nx.obuf[0] = r.index_value_reg;
							nx.state = fcc_pkg::S_STOR;
						end
						else if (r.code == fcc_pkg::C_STORE)
						begin
							nx.obuf = {r.float_accumulator[19:4], r.float_accumulator[35:20],
								r.float_accumulator[51:36]};
							nx.state = fcc_pkg::S_STOR;
						end
						else if (r.code == fcc_pkg::C_F2I)
							nx.state = fcc_pkg::S_EXEC;
					end
				end
			fcc_pkg::S_DEC:
				if (r.stop_pend)
				begin
					nx.snap = r.function_status_reg;
					nx.cnt = 3'h0;
					nx.state = fcc_pkg::S_SAVE;
				end
				else
				begin
					nx.code = r.command_word_reg[15:12];
					nx.command_word_reg = {r.command_word_reg[11:0],
						r.command_word_reg[15:12]};
					nx.function_status_reg[13:12] = n + 2'h1;
					after = (n == 2'h3) ? fcc_pkg::S_CMD : fcc_pkg::S_DEC;
					nx.state = after;
					if (r.prefix)
					begin
						nx.prefix = 1'b0;
						nx.code = fcc_pkg::C_SPECIAL_PREFIX_CMD;
						if (r.command_word_reg[15:12] == fcc_pkg::C_CHAIN)
							nx.state = fcc_pkg::S_PTR;
						else
						begin
							nx.function_status_reg[fcc_pkg::B_ACTIVE] = 1'b0;
							nx.state = fcc_pkg::S_IDLE;
						end
					end
					else
						case (r.command_word_reg[15:12])
							fcc_pkg::C_SPECIAL_PREFIX_CMD:
								nx.prefix = 1'b1;
							fcc_pkg::C_END:
							begin
								nx.function_status_reg[fcc_pkg::B_ACTIVE] = 1'b0;
								nx.state = fcc_pkg::S_IDLE;
							end
							fcc_pkg::C_MODE:
								nx.function_status_reg[fcc_pkg::B_REL] =
									~r.function_status_reg[fcc_pkg::B_REL];
							fcc_pkg::C_COMPL:
								nx.float_accumulator = ~r.float_accumulator;
							fcc_pkg::C_NIDX:
								nx.state = after;
							default:
								nx.state = fcc_pkg::S_PTR;
						endcase
				end
			fcc_pkg::S_OPND:
				if (!r.req)
				begin
					nx.req = 1'b1;
					nx.addr = f_oc_add(r.ea, {13'h0, r.cnt});
				end
				else if (i_mem_ack)
				begin
					nx.req = 1'b0;
					nx.obuf[r.cnt[1:0]] = i_mem_rdata;
					nx.cnt = r.cnt + 3'h1;
					if (r.cnt + 3'h1 == r.total)
						nx.state = fcc_pkg::S_EXEC;
				end
			fcc_pkg::S_EXEC:
			begin
				nx.state = after;
				case (r.code)
					fcc_pkg::C_F2I:
					begin
						nx.obuf[0] = f_f2i(r.float_accumulator);
						nx.float_accumulator[35:20] = nx.obuf[0];
						nx.cnt = 3'h0;
						nx.total = 3'h1;
						nx.state = fcc_pkg::S_STOR;
					end
					fcc_pkg::C_I2F:
						nx.float_accumulator = f_finish(r.obuf[0][15], fcc_pkg::INT_EXP,
							{1'b0, r.obuf[0][15] ? ~r.obuf[0][14:0] : r.obuf[0][14:0], 28'h0},
							dp);
					fcc_pkg::C_LDX:
						nx.index_value_reg = r.obuf[0];
					fcc_pkg::C_ADDX:
						nx.index_value_reg = f_oc_add(r.index_value_reg, r.obuf[0]);
					fcc_pkg::C_LOAD:
						nx.float_accumulator = f_words(r.obuf, dp);
					default:
						nx.float_accumulator = f_arith(r.code, r.float_accumulator,
							f_words(r.obuf, dp), dp);
				endcase
			end
			fcc_pkg::S_STOR, fcc_pkg::S_SAVE:
				if (!r.req)
				begin
					nx.req = 1'b1;
					nx.we = 1'b1;
					if (r.state == fcc_pkg::S_STOR)
					begin
						nx.addr = f_oc_add(r.ea, {13'h0, r.cnt});
						nx.wdata = r.obuf[r.cnt[1:0]];
					end
					else
					begin
						nx.addr = f_oc_add(r.save_area_pointer, {13'h0, r.cnt});
						case (r.cnt)
							3'h0: nx.wdata = r.snap;
							3'h1: nx.wdata = r.command_word_reg;
							3'h2: nx.wdata = r.index_value_reg;
							3'h3: nx.wdata = r.sequence_pointer_reg;
							3'h4: nx.wdata = r.float_accumulator[51:36];
							3'h5: nx.wdata = r.float_accumulator[35:20];
							default: nx.wdata = r.float_accumulator[19:4];
						endcase
					end
				end
				else if (i_mem_ack)
				begin
					nx.req = 1'b0;
					nx.we = 1'b0;
					nx.cnt = r.cnt + 3'h1;
					if (r.state == fcc_pkg::S_STOR && r.cnt + 3'h1 == r.total)
						nx.state = after;
					if (r.state == fcc_pkg::S_SAVE && r.cnt == fcc_pkg::SAVE_LAST)
					begin
						nx.function_status_reg[fcc_pkg::B_ACTIVE] = 1'b0;
						nx.stop_pend = 1'b0;
						nx.state = fcc_pkg::S_IDLE;
					end
				end
			fcc_pkg::S_REST:
				if (!r.req)
				begin
					nx.req = 1'b1;
					nx.we = 1'b0;
					nx.addr = f_oc_add(r.save_area_pointer, {13'h0, r.cnt});
				end
				else if (i_mem_ack)
				begin
					nx.req = 1'b0;
					nx.cnt = r.cnt + 3'h1;
					case (r.cnt)
						3'h0:
						begin
							nx.snap = i_mem_rdata;
							nx.function_status_reg = i_mem_rdata | 16'h8000;
						end
						3'h1: nx.command_word_reg = i_mem_rdata;
						3'h2: nx.index_value_reg = i_mem_rdata;
						3'h3: nx.sequence_pointer_reg = i_mem_rdata;
						3'h4: nx.float_accumulator[51:36] = i_mem_rdata;
						3'h5: nx.float_accumulator[35:20] = i_mem_rdata;
						default:
						begin
							nx.float_accumulator[19:4] = i_mem_rdata;
							nx.function_status_reg[fcc_pkg::B_ACTIVE] = r.snap[fcc_pkg::B_ACTIVE];
							nx.state = r.snap[fcc_pkg::B_ACTIVE] ? fcc_pkg::S_DEC
								: fcc_pkg::S_IDLE;
						end
					endcase
				end
			default:
				nx.state = fcc_pkg::S_IDLE;
		endcase
		// Host writes override the sequencer; an aborted memory request is withdrawn.
		if (i_chan_wr)
			case (i_chan_station)
				fcc_pkg::ST_STATUS:
				begin
					nx.function_status_reg = {nx.function_status_reg[15], i_chan_wdata[14:0]};
					if (i_chan_wdata[fcc_pkg::B_CLEAR])
					begin
						nx.function_status_reg[fcc_pkg::B_ACTIVE] = 1'b0;
						nx.state = fcc_pkg::S_IDLE;
						nx.req = 1'b0;
						nx.we = 1'b0;
						nx.prefix = 1'b0;
						nx.stop_pend = 1'b0;
					end
				end
				fcc_pkg::ST_COLD_SP, fcc_pkg::ST_COLD_DP:
				begin
					nx.sequence_pointer_reg = i_chan_wdata;
					nx.function_status_reg = r.function_status_reg & ~fcc_pkg::COLD_CLEAR_MASK;
					nx.function_status_reg[fcc_pkg::B_DP] = (i_chan_station == fcc_pkg::ST_COLD_DP);
					nx.function_status_reg[13:12] = 2'h0;
					nx.function_status_reg[fcc_pkg::B_ACTIVE] = 1'b1;
					nx.index_value_reg = 16'h0;
					nx.prefix = 1'b0;
					nx.req = 1'b0;
					nx.we = 1'b0;
					nx.state = fcc_pkg::S_CMD;
				end
				fcc_pkg::ST_RESTART:
					if (i_chan_protect)
					begin
						nx.save_area_pointer = i_chan_wdata;
						nx.function_status_reg[fcc_pkg::B_ACTIVE] = 1'b1;
						nx.cnt = 3'h0;
						nx.req = 1'b0;
						nx.we = 1'b0;
						nx.state = fcc_pkg::S_REST;
					end
				fcc_pkg::ST_STOP:
					if (i_chan_protect)
					begin
						nx.save_area_pointer = i_chan_wdata;
						nx.stop_pend = 1'b1;
					end
				default:
					nx.stop_pend = nx.stop_pend;
			endcase
		if (i_chan_rd)
			case (i_chan_station)
				fcc_pkg::ST_STATUS: nx.rdata = r.function_status_reg;
				fcc_pkg::ST_COLD_SP: nx.rdata = r.sequence_pointer_reg;
				fcc_pkg::ST_ACC_W0: nx.rdata = r.float_accumulator[51:36];
				fcc_pkg::ST_ACC_W1: nx.rdata = r.float_accumulator[35:20];
				fcc_pkg::ST_ACC_W2: nx.rdata = r.float_accumulator[19:4];
				default: nx.rdata = 16'h0;
			endcase
	end

	always_ff @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			r <= '0;
			r.state <= fcc_pkg::S_IDLE;
			r.function_status_reg <= fcc_pkg::STATUS_RST;
		end
		else
			r <= nx;
	end

	assign o_chan_rdata = r.rdata;
	assign o_mem_req = r.req;
	assign o_mem_we = r.we;
	assign o_mem_addr = r.addr;
	assign o_mem_wdata = r.wdata;
	assign o_active = r.function_status_reg[fcc_pkg::B_ACTIVE];
	assign o_status = r.function_status_reg;

	// -------------------------------------------------------------
	// Assertions
	// -------------------------------------------------------------
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_rst);

	sequence s_cold_fetch;
		(r.state == fcc_pkg::S_CMD) ##1 (o_mem_req && !o_mem_we);
	endsequence
	property p_cold_dp;
		(i_chan_wr && i_chan_station == fcc_pkg::ST_COLD_DP) |=> o_active && o_status[7]
			&& r.index_value_reg == 16'h0 && (o_status & fcc_pkg::COLD_CLEAR_MASK) == 16'h0;
	endproperty
	a_cold_dp: assert property (p_cold_dp) else $error("cold start state wrong");
	property p_cold_req;
		(i_chan_wr && i_chan_station == fcc_pkg::ST_COLD_SP) ##1 !i_chan_wr |-> s_cold_fetch
			##0 (o_mem_addr == $past(i_chan_wdata, 2) && !o_status[7]);
	endproperty
	a_cold_req: assert property (p_cold_req) else $error("cold start fetch wrong");
	property p_unprot;
		(i_chan_wr && i_chan_station == fcc_pkg::ST_STOP && !i_chan_protect && !r.stop_pend
			&& r.state == fcc_pkg::S_IDLE) |=> r.state == fcc_pkg::S_IDLE;
	endproperty
	a_unprot: assert property (p_unprot) else $error("unprotected stop taken");
	property p_restart;
		(i_chan_wr && i_chan_station == fcc_pkg::ST_RESTART && i_chan_protect) |=>
			r.state == fcc_pkg::S_REST && o_active && r.save_area_pointer == $past(i_chan_wdata);
	endproperty
	a_restart: assert property (p_restart) else $error("restart not taken");
	property p_save_end;
		(r.state == fcc_pkg::S_SAVE && r.cnt == fcc_pkg::SAVE_LAST && o_mem_req && i_mem_ack
			&& !i_chan_wr)
			|=> !o_active && r.state == fcc_pkg::S_IDLE;
	endproperty
	a_save_end: assert property (p_save_end) else $error("save did not end idle");
	property p_save_first;
		(r.state == fcc_pkg::S_SAVE && o_mem_req && r.cnt == 3'h0) |->
			o_mem_we && o_mem_wdata == r.snap && o_mem_addr == r.save_area_pointer;
	endproperty
	a_save_first: assert property (p_save_first) else $error("save word 0 wrong");
	property p_rotate;
		(r.state == fcc_pkg::S_DEC && !r.stop_pend && !i_chan_wr) |=> r.command_word_reg
			== {$past(r.command_word_reg[11:0]), $past(r.command_word_reg[15:12])};
	endproperty
	a_rotate: assert property (p_rotate) else $error("command word not rotated");
	property p_guard;
		(r.state == fcc_pkg::S_EXEC && f_is_float(r.code) && !i_chan_wr) |=>
			r.float_accumulator[3:0] == {4{r.float_accumulator[51]}};
	endproperty
	a_guard: assert property (p_guard) else $error("guard not sign filled");
	property p_div_fault;
		(r.state == fcc_pkg::S_EXEC && r.code == fcc_pkg::C_DIV && r.obuf[0] == 16'h0
			&& !i_chan_wr) |=> r.float_accumulator == f_sat($past(r.float_accumulator[51]));
	endproperty
	a_div_fault: assert property (p_div_fault) else $error("divide fault result wrong");
	property p_rel_ea;
		(r.state == fcc_pkg::S_PTR && o_mem_req && i_mem_ack && r.function_status_reg[9]
			&& r.code == fcc_pkg::C_LDX && !i_chan_wr) |=>
			r.ea == f_oc_add($past(i_mem_rdata), $past(r.sequence_pointer_reg));
	endproperty
	a_rel_ea: assert property (p_rel_ea) else $error("relative address wrong");
endmodule

// >>> hw/fcc_pkg.sv
package fcc_pkg;
	// -------------------------------------------------------------
	// Register channel stations
	// -------------------------------------------------------------
	localparam logic [3:0] ST_STATUS = 4'h0;
	localparam logic [3:0] ST_COLD_SP = 4'h3;
	localparam logic [3:0] ST_COLD_DP = 4'h4;
	localparam logic [3:0] ST_RESTART = 4'h5;
	localparam logic [3:0] ST_ACC_W0 = 4'h7;
	localparam logic [3:0] ST_ACC_W1 = 4'h8;
	localparam logic [3:0] ST_ACC_W2 = 4'h9;
	localparam logic [3:0] ST_STOP = 4'h9;
	// -------------------------------------------------------------
	// Status word fields and reset value
	// -------------------------------------------------------------
	localparam int B_ACTIVE = 15;
	localparam int B_REL = 9;
	localparam int B_UNIT_IDX = 8;
	localparam int B_DP = 7;
	localparam int B_CLEAR = 0;
	localparam int B_CNT = 12;
	localparam logic [15:0] COLD_CLEAR_MASK = 16'h0e48;
	localparam logic [15:0] STATUS_RST = 16'h0000;
	// -------------------------------------------------------------
	// Command codes
	// -------------------------------------------------------------
	localparam logic [3:0] C_SPECIAL_PREFIX_CMD = 4'h0;
	localparam logic [3:0] C_F2I = 4'h1;
	localparam logic [3:0] C_I2F = 4'h2;
	localparam logic [3:0] C_STX = 4'h3;
	localparam logic [3:0] C_END = 4'h4;
	localparam logic [3:0] C_MODE = 4'h5;
	localparam logic [3:0] C_NIDX = 4'h6;
	localparam logic [3:0] C_COMPL = 4'h7;
	localparam logic [3:0] C_SUB = 4'h8;
	localparam logic [3:0] C_MUL = 4'h9;
	localparam logic [3:0] C_DIV = 4'ha;
	localparam logic [3:0] C_LOAD = 4'hb;
	localparam logic [3:0] C_ADDX = 4'hc;
	localparam logic [3:0] C_STORE = 4'hd;
	localparam logic [3:0] C_ADD = 4'he;
	localparam logic [3:0] C_LDX = 4'hf;
	localparam logic [3:0] C_CHAIN = 4'h1;
	// -------------------------------------------------------------
	// Number format and save area
	// -------------------------------------------------------------
	localparam int EXP_MAX = 127;
	localparam int EXP_MIN = -127;
	localparam int EXP_BIAS = 128;
	localparam int INT_EXP = 15;
	localparam int LSB_DP = 4;
	localparam int LSB_SP = 20;
	localparam logic [2:0] SAVE_LAST = 3'h6;

	typedef enum logic [8:0] {
		S_IDLE = 9'h001,
		S_CMD = 9'h002,
		S_DEC = 9'h004,
		S_PTR = 9'h008,
		S_OPND = 9'h010,
		S_EXEC = 9'h020,
		S_STOR = 9'h040,
		S_SAVE = 9'h080,
		S_REST = 9'h100
	} fcc_state_t;

	typedef struct packed {
		fcc_state_t state;
		logic [15:0] function_status_reg;
		logic [15:0] sequence_pointer_reg;
		logic [15:0] command_word_reg;
		logic [15:0] index_value_reg;
		logic [15:0] save_area_pointer;
		logic [15:0] snap;
		logic [15:0] ea;
		logic [51:0] float_accumulator;
		logic [2:0][15:0] obuf;
		logic [2:0] cnt;
		logic [2:0] total;
		logic [3:0] code;
		logic prefix;
		logic stop_pend;
		logic req;
		logic we;
		logic [15:0] addr;
		logic [15:0] wdata;
		logic [15:0] rdata;
	} fcc_regs_t;
endpackage

// >>> tb/fcc_mem_model.sv
`timescale 1ns/1ps
module fcc_mem_model (
	// Clock and reset
	input logic i_core_clk,
	input logic i_rst,
	// Device side
	input logic i_req,
	input logic i_we,
	input logic [15:0] i_addr,
	input logic [15:0] i_wdata,
	input logic [3:0] i_delay,
	output logic o_ack,
	output logic [15:0] o_rdata
);
	logic [15:0] mem [0:65535];
	logic [3:0] cnt;
	initial
		for (int i = 0; i < 65536; i++)
			mem[i] = 16'(i) ^ 16'ha5c3;
	// Read data flips every cycle without an answer, so a stale word never looks valid.
	always @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_ack <= 1'b0;
			cnt <= 4'h0;
			o_rdata <= 16'h0;
		end
		else
		begin
			o_ack <= 1'b0;
			o_rdata <= ~o_rdata;
			cnt <= (i_req && !o_ack) ? cnt + 4'h1 : 4'h0;
			if (i_req && !o_ack && cnt == i_delay)
			begin
				o_ack <= 1'b1;
				cnt <= 4'h0;
				if (i_we)
					mem[i_addr] <= i_wdata;
				else
					o_rdata <= mem[i_addr];
			end
		end
	end
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic i_core_clk = 1'b0;
	logic i_rst = 1'b1;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic prot = 1'b0;
	logic [3:0] stn = 4'h0;
	logic [3:0] dly = 4'h3;
	logic [15:0] wd = 16'h0;
	logic [15:0] rdata, maddr, mwd, mrd, status;
	logic mreq, mwe, ack, active;
	logic [31:0] tab [25] = '{32'h0100_5fb4, 32'h0101_fffd, 32'h0102_0200, 32'h00ff_0100,
		32'h0402_40c0, 32'h0403_1234, 32'h0200_ba44, 32'h0201_0300, 32'h0202_0310,
		32'h0300_bf3f, 32'h0301_ffff, 32'h0302_ffff, 32'h0310_0000, 32'h0311_0000,
		32'h0312_0000, 32'h0600_fb12, 32'h0601_0610, 32'h0602_0620, 32'h0603_0630,
		32'h0604_0640, 32'h0605_4000, 32'h0610_0002, 32'h0624_41d0, 32'h0625_0000,
		32'h0642_fffa};
	int failures = 0;
	int comparisons = 0;
	always #20 i_core_clk = ~i_core_clk;
	fcc_top i_fcc_top (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_chan_wr(wr), .i_chan_rd(rd),
		.i_chan_station(stn), .i_chan_wdata(wd), .i_chan_protect(prot), .o_chan_rdata(rdata),
		.o_mem_req(mreq), .o_mem_we(mwe), .o_mem_addr(maddr), .o_mem_wdata(mwd),
		.i_mem_ack(ack), .i_mem_rdata(mrd), .o_active(active), .o_status(status));
	fcc_mem_model u_mem (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_req(mreq), .i_we(mwe),
		.i_addr(maddr), .i_wdata(mwd), .i_delay(dly), .o_ack(ack), .o_rdata(mrd));
	task automatic tally_and_finish;
		if (failures == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic put(input logic [3:0] s, input logic [15:0] d, input logic p);
		@(negedge i_core_clk);
		wr = 1'b1;
		stn = s;
		wd = d;
		prot = p;
		@(negedge i_core_clk);
		wr = 1'b0;
	endtask
	task automatic get(input logic [3:0] s, input logic [15:0] e);
		@(negedge i_core_clk);
		rd = 1'b1;
		stn = s;
		@(negedge i_core_clk);
		rd = 1'b0;
		@(negedge i_core_clk);
		chk(rdata, e);
	endtask
	task automatic settle;
		repeat (3) @(negedge i_core_clk);
		for (int n = 0; n < 3000 && active !== 1'b0; n++)
			@(negedge i_core_clk);
		if (active !== 1'b0)
		begin
			failures++;
			$display("ERROR %0t sequence did not end", $time);
		end
	endtask
	initial
	begin
		#2000000;
		failures++;
		tally_and_finish();
	end
	initial
	begin
		repeat (4) @(negedge i_core_clk);
		i_rst = 1'b0;
		foreach (tab[k])
			u_mem.mem[tab[k][31:16]] = tab[k][15:0];
		chk(status, 16'h0000);
		put(4'h0, 16'h0f48, 1'b0);
		put(4'h3, 16'h0100, 1'b0);
		@(negedge i_core_clk);
		chk(status, 16'h8100);
		settle();
		get(4'h7, 16'h40c0);
		get(4'h8, 16'h1234);
		get(4'h9, 16'h0000);
		get(4'h3, 16'h0103);
		put(4'h9, 16'h0500, 1'b0);
		repeat (4) @(negedge i_core_clk);
		chk({14'h0, active, mreq}, 16'h0000);
		dly = 4'h0;
		put(4'h9, 16'h0500, 1'b1);
		settle();
		chk(u_mem.mem[16'h0500] & 16'h8380, 16'h0300);
		chk(u_mem.mem[16'h0502], 16'h0100);
		chk(u_mem.mem[16'h0503], 16'h0103);
		chk(u_mem.mem[16'h0504], 16'h40c0);
		chk(u_mem.mem[16'h0505], 16'h1234);
		u_mem.mem[16'h0504] = 16'h4140;
		put(4'h5, 16'h0500, 1'b0);
		repeat (4) @(negedge i_core_clk);
		chk({15'h0, active}, 16'h0000);
		put(4'h5, 16'h0500, 1'b1);
		@(negedge i_core_clk);
		chk({15'h0, active}, 16'h0001);
		settle();
		get(4'h7, 16'h4140);
		get(4'h3, 16'h0103);
		put(4'h4, 16'h0200, 1'b0);
		@(negedge i_core_clk);
		chk(status & 16'h8280, 16'h8080);
		settle();
		get(4'h7, 16'h8000);
		get(4'h8, 16'h0000);
		get(4'h9, 16'h0000);
		// Scaled index, float to integer store, then a negative integer converted back.
		put(4'h0, 16'h0000, 1'b0);
		put(4'h3, 16'h0600, 1'b0);
		settle();
		chk(u_mem.mem[16'h0632], 16'h0005);
		get(4'h7, 16'hbe2f);
		get(4'h8, 16'hffff);
		get(4'h9, 16'hffff);
		get(4'h3, 16'h0606);
		tally_and_finish();
	end
endmodule
